// ### design/sgoc_top.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sgoc_consts.svh"
module sgoc_top
    import sgoc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Object status inputs
    input wire logic open_sts_i,
    input wire logic close_sts_i,
    input wire logic cart_inserted_input_i,
    input wire logic cart_withdrawn_input_i,
    input wire logic ready_i,
    input wire logic sync_ok_i,
    // Command sources
    input wire logic local_open_i,
    input wire logic local_close_i,
    input wire logic remote_open_i,
    input wire logic remote_close_i,
    input wire logic app_open_i,
    input wire logic app_close_i,
    input wire logic reclose_pending_i,
    // Relay and status outputs
    output logic open_cmd_o,
    output logic close_cmd_o,
    output logic final_trip_o,
    output logic cmd_fail_o,
    output logic [1:0] brk_status_o,
    output logic [2:0] wd_status_o
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] inc_sat(input logic [31:0] v);
        inc_sat = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
    endfunction : inc_sat

    function automatic logic [1:0] pos_of(input logic o, input logic c);
        pos_of = {c, o};
    endfunction : pos_of

    logic tick;
    sgoc_mstick u_tick
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] ctrl_q, ctrl_d, trav_q, trav_d, cpul_q, cpul_d;
    logic [31:0] opul_q, opul_d, tout_q, tout_d, ftrp_q, ftrp_d;
    logic [31:0] n_opn_q, n_opn_d, n_cls_q, n_cls_d;
    logic [31:0] f_opn_q, f_opn_d, f_cls_q, f_cls_d;
    logic [31:0] rdata_q, rdata_d;
    sgoc_type_t otype;
    logic remote, use_sync, panel_ok, panel_opn, panel_cls;
    logic [1:0] rdy_mode;
    assign otype = sgoc_type_t'(ctrl_q[`SGOC_F_TYPE_LO +: 2]);
    assign remote = ctrl_q[`SGOC_F_REMOTE];
    assign use_sync = ctrl_q[`SGOC_F_SYNC];
    assign rdy_mode = ctrl_q[`SGOC_F_RDY_LO +: 2];
    // Panel writes honoured only at or above the required level
    assign panel_ok = wdata_i[`SGOC_F_USRLVL_LO +: 2]
        >= ctrl_q[`SGOC_F_ACC_LO +: 2];
    assign panel_opn = wr_i && addr_i == `SGOC_A_CTRL && panel_ok
        && wdata_i[`SGOC_F_PANEL_OPN];
    assign panel_cls = wr_i && addr_i == `SGOC_A_CTRL && panel_ok
        && wdata_i[`SGOC_F_PANEL_CLS];

    // ****************************************
    // Position monitoring
    // ****************************************
    logic [1:0] raw_pos, last_pos_q, last_pos_d, brk_q, brk_d;
    logic [31:0] trav_cnt_q, trav_cnt_d;
    logic [2:0] wd_q, wd_d;

    // Settled positions immediate, mid or bad after traverse time
    always_comb
    begin
        raw_pos = pos_of(open_sts_i, close_sts_i);
        last_pos_d = raw_pos;
        brk_d = brk_q;
        trav_cnt_d = trav_cnt_q;
        if (raw_pos != last_pos_q)
            trav_cnt_d = 32'h0000_0000;
        else if (tick && trav_cnt_q < trav_q)
            trav_cnt_d = trav_cnt_q + 32'h0000_0001;
        if (raw_pos == SGOC_OPEN || raw_pos == SGOC_CLOSED)
            brk_d = raw_pos;
        else if (raw_pos == last_pos_q && trav_cnt_q >= trav_q)
            brk_d = raw_pos;
        if (otype == SGOC_WDCB)
            wd_d = {1'b0, cart_inserted_input_i, cart_withdrawn_input_i};
        else
            wd_d = 3'h4;
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    sgoc_state_t st_q, st_d;
    logic is_close_q, is_close_d, fail_d, fail_q;
    logic opn_q, opn_d, cls_q, cls_d;
    logic [31:0] pcnt_q, pcnt_d, tcnt_q, tcnt_d;
    logic req_open, req_close, can_ctrl, rdy_ok, sync_ok, done;
    logic ok_open, ok_close, bad_open, bad_close, trip_ev;

    // Source select, permission checks and pulse timing
    always_comb
    begin
        can_ctrl = (otype != SGOC_EARTH);
        req_open = app_open_i || panel_opn
            || (!remote && local_open_i)
            || (remote && remote_open_i);
        req_close = app_close_i || panel_cls
            || (!remote && local_close_i)
            || (remote && remote_close_i);
        rdy_ok = (rdy_mode == 2'h0) ? ready_i :
            (rdy_mode == 2'h1) ? !ready_i : 1'b1;
        sync_ok = !use_sync || sync_ok_i;
        if (otype == SGOC_DISC)
        begin
            rdy_ok = 1'b1;
            sync_ok = 1'b1;
        end
        st_d = st_q;
        is_close_d = is_close_q;
        opn_d = 1'b0;
        cls_d = 1'b0;
        pcnt_d = pcnt_q;
        tcnt_d = tcnt_q;
        fail_d = 1'b0;
        ok_open = 1'b0;
        ok_close = 1'b0;
        bad_open = 1'b0;
        bad_close = 1'b0;
        trip_ev = 1'b0;
        done = is_close_q ? (brk_q == SGOC_CLOSED) : (brk_q == SGOC_OPEN);
        case (st_q)
            SGOC_IDLE:
            begin
                pcnt_d = 32'h0000_0000;
                tcnt_d = 32'h0000_0000;
                if (can_ctrl && req_open)
                begin
                    is_close_d = 1'b0;
                    opn_d = 1'b1;
                    st_d = SGOC_PULSE;
                end
                else if (can_ctrl && req_close)
                begin
                    is_close_d = 1'b1;
                    if (rdy_ok && sync_ok)
                    begin
                        cls_d = 1'b1;
                        st_d = SGOC_PULSE;
                    end
                    else
                    begin
                        bad_close = 1'b1;
                        fail_d = 1'b1;
                    end
                end
            end
            SGOC_PULSE:
            begin
                if (tick)
                begin
                    pcnt_d = pcnt_q + 32'h0000_0001;
                    tcnt_d = tcnt_q + 32'h0000_0001;
                end
                // Pulse drops at cap or on new status
                if (done || pcnt_q >= (is_close_q ? cpul_q : opul_q))
                    st_d = SGOC_WAIT;
                else
                begin
                    opn_d = !is_close_q;
                    cls_d = is_close_q;
                end
            end
            SGOC_WAIT:
            begin
                if (tick)
                    tcnt_d = tcnt_q + 32'h0000_0001;
                if (done)
                begin
                    st_d = SGOC_IDLE;
                    ok_open = !is_close_q;
                    ok_close = is_close_q;
                    trip_ev = !is_close_q;
                end
                else if (tcnt_q >= tout_q)
                begin
                    st_d = SGOC_IDLE;
                    fail_d = 1'b1;
                    bad_open = !is_close_q;
                    bad_close = is_close_q;
                end
            end
            default:
                st_d = SGOC_IDLE;
        endcase
    end

    // ****************************************
    // Final trip output
    // ****************************************
    logic ft_q, ft_d;
    logic [31:0] ftcnt_q, ftcnt_d;

    // Pulse on finished open unless reclose expected; zero holds it
    always_comb
    begin
        ft_d = ft_q;
        ftcnt_d = ftcnt_q;
        if (trip_ev && !reclose_pending_i)
        begin
            ft_d = 1'b1;
            ftcnt_d = 32'h0000_0000;
        end
        else if (ft_q && ftrp_q != 32'h0000_0000)
        begin
            if (ftcnt_q >= ftrp_q)
                ft_d = 1'b0;
            else if (tick)
                ftcnt_d = ftcnt_q + 32'h0000_0001;
        end
        else if (ft_q && is_close_q && st_q != SGOC_IDLE)
            ft_d = 1'b0;
    end

    // ****************************************
    // Register writes, counters and read port
    // ****************************************
    always_comb
    begin
        ctrl_d = ctrl_q;
        trav_d = trav_q;
        cpul_d = cpul_q;
        opul_d = opul_q;
        tout_d = tout_q;
        ftrp_d = ftrp_q;
        if (wr_i)
        begin
            case (addr_i)
                `SGOC_A_CTRL: ctrl_d = {24'h000000, wdata_i[7:0]};
                `SGOC_A_TRAV: trav_d = wdata_i;
                `SGOC_A_CPUL: cpul_d = wdata_i;
                `SGOC_A_OPUL: opul_d = wdata_i;
                `SGOC_A_TOUT: tout_d = wdata_i;
                `SGOC_A_FTRP: ftrp_d = wdata_i;
                default: ctrl_d = ctrl_q;
            endcase
        end
        n_opn_d = ok_open ? inc_sat(n_opn_q) : n_opn_q;
        n_cls_d = ok_close ? inc_sat(n_cls_q) : n_cls_q;
        f_opn_d = bad_open ? inc_sat(f_opn_q) : f_opn_q;
        f_cls_d = bad_close ? inc_sat(f_cls_q) : f_cls_q;
        if (wr_i && addr_i == `SGOC_A_CLR && wdata_i[0])
        begin
            n_opn_d = 32'h0000_0000;
            n_cls_d = 32'h0000_0000;
            f_opn_d = 32'h0000_0000;
            f_cls_d = 32'h0000_0000;
        end
        rdata_d = 32'h0000_0000;
        if (rd_i)
        begin
            case (addr_i)
                `SGOC_A_CTRL: rdata_d = ctrl_q;
                `SGOC_A_TRAV: rdata_d = trav_q;
                `SGOC_A_CPUL: rdata_d = cpul_q;
                `SGOC_A_OPUL: rdata_d = opul_q;
                `SGOC_A_TOUT: rdata_d = tout_q;
                `SGOC_A_FTRP: rdata_d = ftrp_q;
                `SGOC_A_STAT: rdata_d = {24'h000000, ft_q, wd_q,
                    st_q, brk_q};
                `SGOC_A_NOPN: rdata_d = n_opn_q;
                `SGOC_A_NCLS: rdata_d = n_cls_q;
                `SGOC_A_FOPN: rdata_d = f_opn_q;
                `SGOC_A_FCLS: rdata_d = f_cls_q;
                default: rdata_d = 32'h0000_0000; // Clear reads 0
            endcase
        end
    end

    // All state registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= `SGOC_RST_CTRL;
            trav_q <= `SGOC_RST_TRAV_MS;
            cpul_q <= `SGOC_RST_CPUL_MS;
            opul_q <= `SGOC_RST_OPUL_MS;
            tout_q <= `SGOC_RST_TOUT_MS;
            ftrp_q <= `SGOC_RST_FTRP_MS;
            n_opn_q <= 32'h0000_0000;
            n_cls_q <= 32'h0000_0000;
            f_opn_q <= 32'h0000_0000;
            f_cls_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            last_pos_q <= 2'h0;
            brk_q <= 2'h0;
            trav_cnt_q <= 32'h0000_0000;
            wd_q <= 3'h4;
            st_q <= SGOC_IDLE;
            is_close_q <= 1'b0;
            opn_q <= 1'b0;
            cls_q <= 1'b0;
            fail_q <= 1'b0;
            pcnt_q <= 32'h0000_0000;
            tcnt_q <= 32'h0000_0000;
            ft_q <= 1'b0;
            ftcnt_q <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            trav_q <= trav_d;
            cpul_q <= cpul_d;
            opul_q <= opul_d;
            tout_q <= tout_d;
            ftrp_q <= ftrp_d;
            n_opn_q <= n_opn_d;
            n_cls_q <= n_cls_d;
            f_opn_q <= f_opn_d;
            f_cls_q <= f_cls_d;
            rdata_q <= rdata_d;
            last_pos_q <= last_pos_d;
            brk_q <= brk_d;
            trav_cnt_q <= trav_cnt_d;
            wd_q <= wd_d;
            st_q <= st_d;
            is_close_q <= is_close_d;
            opn_q <= opn_d;
            cls_q <= cls_d;
            fail_q <= fail_d;
            pcnt_q <= pcnt_d;
            tcnt_q <= tcnt_d;
            ft_q <= ft_d;
            ftcnt_q <= ftcnt_d;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o = rdata_q;
    assign open_cmd_o = opn_q;
    assign close_cmd_o = cls_q;
    assign final_trip_o = ft_q;
    assign cmd_fail_o = fail_q;
    assign brk_status_o = brk_q;
    assign wd_status_o = wd_q;
endmodule : sgoc_top

// ### design/sgoc_consts.svh
`ifndef SGOC_CONSTS_SVH
`define SGOC_CONSTS_SVH
// ****************************************
// Clock and millisecond tick
// ****************************************
`define SGOC_CLK_HZ 20000000
`define SGOC_TICK_MS 1
`define SGOC_TICK_CYC ((`SGOC_CLK_HZ / 1000) * `SGOC_TICK_MS)
// ****************************************
// Register offsets
// ****************************************
`define SGOC_A_CTRL 4'h0
`define SGOC_A_TRAV 4'h1
`define SGOC_A_CPUL 4'h2
`define SGOC_A_OPUL 4'h3
`define SGOC_A_TOUT 4'h4
`define SGOC_A_FTRP 4'h5
`define SGOC_A_STAT 4'h6
`define SGOC_A_NOPN 4'h7
`define SGOC_A_NCLS 4'h8
`define SGOC_A_FOPN 4'h9
`define SGOC_A_FCLS 4'hA
`define SGOC_A_CLR 4'hB
// ****************************************
// Control field positions
// ****************************************
`define SGOC_F_TYPE_LO 0
`define SGOC_F_REMOTE 2
`define SGOC_F_SYNC 3
`define SGOC_F_RDY_LO 4
`define SGOC_F_ACC_LO 6
`define SGOC_F_USRLVL_LO 8
`define SGOC_F_PANEL_OPN 10
`define SGOC_F_PANEL_CLS 11
// ****************************************
// Reset values (times in ms)
// ****************************************
`define SGOC_RST_CTRL 32'h0000_00A5
`define SGOC_RST_TRAV_MS 32'd200
`define SGOC_RST_CPUL_MS 32'd200
`define SGOC_RST_OPUL_MS 32'd200
`define SGOC_RST_TOUT_MS 32'd10000
`define SGOC_RST_FTRP_MS 32'd200
`endif

// ### design/sgoc_pkg.sv
package sgoc_pkg;
    // Object type
    typedef enum logic [1:0] {
        SGOC_WDCB = 2'b00,
        SGOC_CB = 2'b01,
        SGOC_DISC = 2'b10,
        SGOC_EARTH = 2'b11
    } sgoc_type_t;
    // Breaker position
    typedef enum logic [1:0] {
        SGOC_MID = 2'b00,
        SGOC_OPEN = 2'b01,
        SGOC_CLOSED = 2'b10,
        SGOC_BAD = 2'b11
    } sgoc_pos_t;
    // Command sequencer
    typedef enum logic [1:0] {
        SGOC_IDLE = 2'b00,
        SGOC_PULSE = 2'b01,
        SGOC_WAIT = 2'b10
    } sgoc_state_t;
endpackage : sgoc_pkg

// ### design/sgoc_mstick.sv
`timescale 1ns/1ps
`include "sgoc_consts.svh"
// One-cycle enable every millisecond
module sgoc_mstick
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick
    output logic tick_o
);
    localparam logic [14:0] LAST = 15'(`SGOC_TICK_CYC - 1);
    logic [14:0] cnt_q;
    logic [14:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // Divider next state
    always_comb
    begin
        tick_d = (cnt_q == LAST);
        cnt_d = tick_d ? 15'h0000 : cnt_q + 15'h0001;
    end

    // Divider registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 15'h0000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule : sgoc_mstick

// ### verification/sgoc_top_sva.sv
`timescale 1ns/1ps
// ****
// Port checker for the object control block
// ****
module sgoc_top_sva
    import sgoc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Object status
    input wire logic open_sts_i,
    input wire logic close_sts_i,
    // Relay and status outputs
    input wire logic open_cmd_o,
    input wire logic close_cmd_o,
    input wire logic cmd_fail_o,
    input wire logic [1:0] brk_status_o
);
    // One clock domain for all properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Relay pulses
    AST_NO_BOTH: assert property (!(open_cmd_o && close_cmd_o))
        else $error("both relays high");
    AST_OPEN_END: assert property (open_cmd_o && open_sts_i &&
        !close_sts_i |-> ##[1:4] !open_cmd_o)
        else $error("open relay held after open reached");
    AST_CLOSE_END: assert property (close_cmd_o && close_sts_i &&
        !open_sts_i |-> ##[1:4] !close_cmd_o)
        else $error("close relay held after close reached");
    // Position reporting
    AST_STS_OPEN: assert property ((open_sts_i && !close_sts_i)[*3]
        |-> brk_status_o == SGOC_OPEN)
        else $error("open position not reported");
    AST_STS_CLOSED: assert property ((close_sts_i && !open_sts_i)[*3]
        |-> brk_status_o == SGOC_CLOSED)
        else $error("closed position not reported");
    AST_MID_CAUSE: assert property (brk_status_o == SGOC_MID &&
        $past(brk_status_o) != SGOC_MID |-> $past(!open_sts_i && !close_sts_i))
        else $error("intermediate without cause");
    AST_BAD_CAUSE: assert property (brk_status_o == SGOC_BAD &&
        $past(brk_status_o) != SGOC_BAD |-> $past(open_sts_i && close_sts_i))
        else $error("bad without cause");
    // Failure reporting
    AST_FAIL_ONE: assert property (cmd_fail_o |=> !cmd_fail_o)
        else $error("fail pulse longer than one cycle");
    AST_FAIL_END: assert property (cmd_fail_o |=>
        !open_cmd_o && !close_cmd_o)
        else $error("relay active after failure");
    // Main scenarios
    COV_OPEN: cover property ($rose(open_cmd_o));
    COV_CLOSE: cover property ($rose(close_cmd_o));
    COV_FAIL: cover property (cmd_fail_o);
endmodule : sgoc_top_sva

bind sgoc_top sgoc_top_sva sgoc_top_sva_i (.clk_i(clk_i), .rst_i(rst_i),
    .open_sts_i(open_sts_i), .close_sts_i(close_sts_i),
    .open_cmd_o(open_cmd_o), .close_cmd_o(close_cmd_o),
    .cmd_fail_o(cmd_fail_o), .brk_status_o(brk_status_o));

// ### verification/sgoc_object_model.sv
`timescale 1ns/1ps
// ****
// Switching object model
// ****
module sgoc_object_model
(
    // Clock
    input wire logic clk_i,
    // Relays and fault mode
    input wire logic open_cmd_i,
    input wire logic close_cmd_i,
    input wire logic [1:0] mode_i,
    // Position contacts
    output logic open_sts_o,
    output logic close_sts_o
);
    logic [2:0] dly_q = 3'h0;
    logic pos_open_q = 1'b0;
    // Travel five cycles after a relay pulls in, unless stuck
    always @(posedge clk_i)
    begin
        dly_q <= (open_cmd_i || close_cmd_i) ? dly_q + 3'h1 : 3'h0;
        if (dly_q == 3'h4 && mode_i == 2'h0)
            pos_open_q <= open_cmd_i;
    end
    // Contacts follow the position, or both stick high or low
    assign open_sts_o = (mode_i == 2'h0) ? pos_open_q : ~mode_i[1];
    assign close_sts_o = (mode_i == 2'h0) ? ~pos_open_q : ~mode_i[1];
endmodule : sgoc_object_model

// ### verification/sgoc_top_bench.sv
`timescale 1ns/1ps
`include "sgoc_consts.svh"
// ****
// Object control bench
// ****
module sgoc_top_bench
    import sgoc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [5:0] req = 6'h0;
    logic ready_i = 1'b1;
    logic sync_ok_i = 1'b1;
    logic cart_in = 1'b0;
    logic cart_out = 1'b0;
    logic pend = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [31:0] rdata_o;
    logic open_sts, close_sts, open_cmd_o, close_cmd_o, final_trip_o;
    logic cmd_fail_o;
    logic [1:0] brk_status_o;
    logic [2:0] wd_status_o;
    int errors = 0;
    int compares = 0;
    // Clock at 20 MHz
    always #25 clk_i = ~clk_i;
    // Block under test and the object behind it
    sgoc_top sgoc_top_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .open_sts_i(open_sts), .close_sts_i(close_sts),
        .cart_inserted_input_i(cart_in), .cart_withdrawn_input_i(cart_out),
        .ready_i(ready_i), .sync_ok_i(sync_ok_i),
        .local_open_i(req[0]), .local_close_i(req[1]),
        .remote_open_i(req[2]), .remote_close_i(req[3]),
        .app_open_i(req[4]), .app_close_i(req[5]),
        .reclose_pending_i(pend), .open_cmd_o(open_cmd_o),
        .close_cmd_o(close_cmd_o), .final_trip_o(final_trip_o),
        .cmd_fail_o(cmd_fail_o), .brk_status_o(brk_status_o),
        .wd_status_o(wd_status_o));
    sgoc_object_model sgoc_object_model_i (.clk_i(clk_i),
        .open_cmd_i(open_cmd_o), .close_cmd_i(close_cmd_o), .mode_i(mode),
        .open_sts_o(open_sts), .close_sts_o(close_sts));
    // Verdict and end of run
    task automatic end_of_test();
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // Value comparison
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s exp %0h got %0h", n, e, s);
        end
    endtask : chk
    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
        input string n);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(n, e, rdata_o);
    endtask : rd
    // One-cycle command request
    task automatic fire(input logic [5:0] m);
        @(posedge clk_i);
        req <= m;
        @(posedge clk_i);
        req <= 6'h0;
    endtask : fire
    // Output selector: 0 open, 1 close, 2 fail, 3 position, 4 final trip
    function automatic logic hit(input int w, input logic [1:0] v);
        case (w)
            0: return {1'b0, open_cmd_o} === v;
            1: return {1'b0, close_cmd_o} === v;
            2: return {1'b0, cmd_fail_o} === v;
            4: return {1'b0, final_trip_o} === v;
            default: return brk_status_o === v;
        endcase
    endfunction : hit
    // Bounded wait for an output value
    task automatic wait_for(input int w, input logic [1:0] v, input int lim);
        int n;
        n = 0;
        #1;
        while (n < lim && !hit(w, v))
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        compares++;
        if (!hit(w, v))
        begin
            errors++;
            $display("CHECK FAILED wait %0d exp %0h got timeout", w, v);
            end_of_test();
        end
    endtask : wait_for
    // Request that must leave both relays at rest
    task automatic quiet(input logic [5:0] m);
        fire(m);
        repeat (8)
        begin
            @(posedge clk_i);
            #1;
            chk("relays", 32'h0, {30'h0, open_cmd_o, close_cmd_o});
        end
    endtask : quiet
    // Reset values, unmapped place, then short times
    task automatic t_defaults();
        logic [31:0] e[13];
        e = '{32'hA5, 32'hC8, 32'hC8, 32'hC8, 32'h2710, 32'hC8, 32'h0,
            32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int a = 0; a < 13; a++)
            if (a != 6)
                rd(4'(a), e[a], "reset value");
        chk("wd status", 32'h4, {29'h0, wd_status_o});
        wr(`SGOC_A_TRAV, 32'h1);
        wr(`SGOC_A_OPUL, 32'h2);
        wr(`SGOC_A_TOUT, 32'h2);
        wr(`SGOC_A_FTRP, 32'h0);
    endtask : t_defaults
    // Successful open (c=0) or close (c=1) with its counter
    task automatic t_cmd(input logic c, input logic [5:0] m, input logic p,
        input logic [31:0] n);
        @(posedge clk_i);
        pend <= p;
        fire(m);
        wait_for(c, 2'h1, 4);
        wait_for(3, c ? SGOC_CLOSED : SGOC_OPEN, 40);
        wait_for(c, 2'h0, 5);
        rd(c ? `SGOC_A_NCLS : `SGOC_A_NOPN, n, "ok count");
        if (!c)
            chk("final trip", {31'h0, ~p}, {31'h0, final_trip_o});
    endtask : t_cmd
    // Close refused by ready low, ready high and synchrocheck
    task automatic t_refused();
        logic [31:0] c[3];
        logic r[3];
        c = '{32'h81, 32'h91, 32'hA9};
        r = '{1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 3; i++)
        begin
            wr(`SGOC_A_CTRL, c[i]);
            @(posedge clk_i);
            ready_i <= r[i];
            sync_ok_i <= ~c[i][3];
            fire(6'h02);
            wait_for(2, 2'h1, 4);
            chk("close relay", 32'h0, {31'h0, close_cmd_o});
            rd(`SGOC_A_FCLS, 32'(i + 1), "close fail");
        end
        wr(`SGOC_A_CTRL, 32'hA1);
    endtask : t_refused
    // Stuck object: timeout, intermediate, then bad
    task automatic t_timeout();
        @(posedge clk_i);
        mode <= 2'h2;
        fire(6'h01);
        wait_for(0, 2'h1, 4);
        wait_for(2, 2'h1, 50000);
        wait_for(3, SGOC_MID, 45000);
        rd(`SGOC_A_FOPN, 32'h1, "open fail");
        @(posedge clk_i);
        mode <= 2'h1;
        wait_for(3, SGOC_BAD, 45000);
        @(posedge clk_i);
        mode <= 2'h0;
        wait_for(3, SGOC_CLOSED, 40);
    endtask : t_timeout
    // Counter clear and self-returning control
    task automatic t_clear();
        wr(`SGOC_A_CLR, 32'h1);
        for (int a = 7; a < 12; a++)
            rd(4'(a), 32'h0, "cleared");
    endtask : t_clear
    // Earth switch, withdrawable cart and disconnector
    task automatic t_types();
        wr(`SGOC_A_CTRL, 32'hA3);
        quiet(6'h01);
        chk("wd status", 32'h4, {29'h0, wd_status_o});
        wr(`SGOC_A_CTRL, 32'hA0);
        @(posedge clk_i);
        cart_in <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("wd status", 32'h2, {29'h0, wd_status_o});
        @(posedge clk_i);
        cart_in <= 1'b0;
        cart_out <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("wd status", 32'h1, {29'h0, wd_status_o});
        wr(`SGOC_A_CTRL, 32'h82);
        @(posedge clk_i);
        ready_i <= 1'b0;
        t_cmd(0, 6'h01, 0, 32'h1);
        t_cmd(1, 6'h02, 0, 32'h1);
    endtask : t_types
    // Panel open refused below the access level, taken at it
    task automatic t_panel();
        wr(`SGOC_A_FTRP, 32'h1);
        wr(`SGOC_A_CTRL, 32'h582);
        repeat (8)
        begin
            @(posedge clk_i);
            #1;
            chk("panel relay", 32'h0, {31'h0, open_cmd_o});
        end
        wr(`SGOC_A_CTRL, 32'h682);
        wait_for(0, 2'h1, 4);
        wait_for(4, 2'h1, 40);
        wait_for(4, 2'h0, 21000);
        rd(`SGOC_A_NOPN, 32'h2, "panel count");
    endtask : t_panel
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_defaults();
        t_cmd(0, 6'h04, 1, 32'h1);
        t_cmd(1, 6'h20, 0, 32'h1);
        t_cmd(0, 6'h10, 0, 32'h2);
        quiet(6'h02);
        wr(`SGOC_A_CTRL, 32'hA1);
        quiet(6'h08);
        t_cmd(1, 6'h02, 0, 32'h2);
        t_refused();
        t_timeout();
        t_clear();
        t_types();
        t_panel();
        end_of_test();
    end
endmodule : sgoc_top_bench
